// [logic/pmc_pir_motion_config_unit.sv]
/*
 * Top of the motion configuration unit: configuration storage, motion
 * detection with pulse window and blind interval, event line drive and the
 * readout frame. Assumes the readout bit protocol and the filters live outside.
 */
`timescale 1ns/1ns
module pmc_pir_motion_config_unit import pmc_pkg::*; #(
  parameter int IDLE_CYC = IDLE_LATCH_CYC,
  parameter int READ_CYC = READABLE_CYC,
  parameter int HALF_CYC = HALF_SEC_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Configuration serial input.
  input wire logic config_serial_input,
  // Event line, split into level, drive value and enable (low drives).
  input wire logic event_in,
  output logic event_out,
  output logic event_oe_n,
  // Sample inputs from the converter and filters.
  input wire logic sample_strobe,
  input wire logic [SMP_W-1:0] bp_sample,
  input wire logic [SMP_W-1:0] lp_sample,
  input wire logic [SMP_W-1:0] temp_sample,
  input wire logic in_range,
  // Configuration and status.
  output logic [CFG_W-1:0] motion_configuration,
  output logic config_valid,
  output logic config_readable,
  output logic hpf_low_corner,
  output logic alarm_active,
  // Readout frame.
  output logic [FRAME_W-1:0] frame_data,
  output logic frame_strobe
);
  typedef enum {ST_IDLE, ST_ALARM, ST_READY, ST_BLIND} pmc_state_type;

  logic [CFG_W-1:0] rx_word;
  logic rx_strobe;
  logic pulse;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic cfg_valid_r, cfg_valid_nxt;
  logic readable_r, readable_nxt;
  logic [TMR_W-1:0] rd_cnt_r, rd_cnt_nxt;
  logic [27:0] half_cnt_r, half_cnt_nxt;
  logic half_tick;
  logic [4:0] win_r, win_nxt;
  logic [2:0] pcnt_r, pcnt_nxt;
  logic [4:0] blind_r, blind_nxt;
  pmc_state_type state_r, state_nxt;
  logic drive_r, drive_nxt;
  logic [FRAME_W-1:0] frame_r, frame_nxt;
  logic frame_strobe_r, frame_strobe_nxt;
  logic [1:0] mode;
  logic trigger;
  logic host_low;
  logic [SMP_W-1:0] sel_sample;

  // ******************************************************************
  // Sub-blocks
  // ******************************************************************
  pmc_serial_rx #(.IDLE_CYC(IDLE_CYC)) u_rx (
    .clock(clock),
    .reset_n(reset_n),
    .config_serial_input(config_serial_input),
    .word_r(rx_word),
    .word_strobe_r(rx_strobe)
  );

  pmc_pulse_detect u_pulse (
    .clock(clock),
    .reset_n(reset_n),
    .sample_strobe(sample_strobe),
    .bp_sample(bp_sample),
    .threshold(cfg_r[THR_HI:THR_LO]),
    .count_any_sign(cfg_r[CMODE_BIT]),
    .pulse_r(pulse)
  );

  // ******************************************************************
  // Configuration storage
  // ******************************************************************
  // Reset clears the word along with the valid flag; the word still carries no
  // meaning until the first complete load.
  always_comb begin
    cfg_nxt = cfg_r;
    cfg_valid_nxt = cfg_valid_r;
    readable_nxt = readable_r;
    rd_cnt_nxt = rd_cnt_r;
    if (rx_strobe) begin
      cfg_nxt = rx_word;
      cfg_valid_nxt = 1'b1; // see RQ1
      readable_nxt = 1'b0;
      rd_cnt_nxt = TMR_W'(READ_CYC);
    end else if (rd_cnt_r != '0) begin
      rd_cnt_nxt = rd_cnt_r - 1'b1;
      if (rd_cnt_r == TMR_W'(1)) begin
        readable_nxt = 1'b1; // see RQ22
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cfg_r <= '0;
      cfg_valid_r <= 1'b0;
      readable_r <= 1'b0;
      rd_cnt_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      cfg_valid_r <= cfg_valid_nxt;
      readable_r <= readable_nxt;
      rd_cnt_r <= rd_cnt_nxt;
    end
  end

  assign mode = cfg_r[MODE_HI:MODE_LO]; // see RQ10
  assign hpf_low_corner = cfg_r[HPF_BIT]; // see RQ15
  assign host_low = drive_r && !event_in;

  // ******************************************************************
  // Half-second time base
  // ******************************************************************
  // One prescaler serves both window and blind timing; it restarts on an
  // alarm clear so the blind interval is not short by a partial step.
  always_comb begin
    half_tick = half_cnt_r == 28'(HALF_CYC - 1);
    half_cnt_nxt = half_cnt_r + 1'b1; // see RQ24
    if (half_tick || (state_r == ST_ALARM && host_low)) begin
      half_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      half_cnt_r <= '0;
    end else begin
      half_cnt_r <= half_cnt_nxt;
    end
  end

  // ******************************************************************
  // Pulse window
  // ******************************************************************
  // The window opens at the first pulse and closes after its length; this
  // trades a true sliding window for one counter per unit.
  always_comb begin
    win_nxt = win_r;
    pcnt_nxt = pcnt_r;
    trigger = 1'b0;
    if (state_r != ST_IDLE || mode != MODE_WAKE || !cfg_valid_r) begin
      win_nxt = '0;
      pcnt_nxt = '0; // see RQ4
    end else begin
      if (win_r != '0 && half_tick) begin
        win_nxt = win_r - 1'b1; // see RQ9
        if (win_r == 5'd1) begin
          pcnt_nxt = '0;
        end
      end
      if (pulse) begin
        if (pcnt_r == '0 || (win_r == 5'd1 && half_tick)) begin
          win_nxt = 5'((cfg_r[WIN_HI:WIN_LO] + 3'd1) * WIN_STEP_HALVES);
          pcnt_nxt = 3'd1;
        end else begin
          pcnt_nxt = pcnt_r + 1'b1;
        end
        if (pcnt_nxt >= {1'b0, cfg_r[PCNT_HI:PCNT_LO]} + 3'd1) begin
          trigger = 1'b1; // see RQ8
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      win_r <= '0;
      pcnt_r <= '0;
    end else begin
      win_r <= win_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  // ******************************************************************
  // Event line control
  // ******************************************************************
  // The line is only ever driven high; the host overrides it by pulling
  // low, which the unit sees as a low level while it is still driving.
  always_comb begin
    state_nxt = state_r;
    drive_nxt = drive_r;
    blind_nxt = blind_r;
    case (state_r)
      ST_IDLE: begin
        if (trigger) begin
          state_nxt = ST_ALARM;
          drive_nxt = 1'b1; // see RQ2
        end else if (cfg_valid_r && mode == MODE_IRQ && sample_strobe) begin
          state_nxt = ST_READY;
          drive_nxt = 1'b1; // see RQ11
        end
      end
      ST_ALARM: begin
        // Held high until the host pulls it down; released here only then.
        if (host_low) begin
          state_nxt = ST_BLIND;
          drive_nxt = 1'b0;
          blind_nxt = {1'b0, cfg_r[BLIND_HI:BLIND_LO]} + 5'd1; // see RQ6 RQ7
        end
      end
      ST_READY: begin
        if (host_low) begin
          state_nxt = ST_IDLE;
          drive_nxt = 1'b0;
        end
      end
      ST_BLIND: begin
        if (half_tick) begin
          blind_nxt = blind_r - 1'b1; // see RQ4 RQ24
          if (blind_r == 5'd1) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        drive_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      drive_r <= 1'b0;
      blind_r <= '0;
    end else begin
      state_r <= state_nxt;
      drive_r <= drive_nxt;
      blind_r <= blind_nxt;
    end
  end

  assign event_out = drive_r;
  assign event_oe_n = ~drive_r;
  assign alarm_active = state_r == ST_ALARM;

  // ******************************************************************
  // Readout frame
  // ******************************************************************
  // Sample source follows the source field; the reserved code gives zero.
  always_comb begin
    case (cfg_r[SRC_HI:SRC_LO])
      SRC_BPF: sel_sample = bp_sample; // see RQ12 RQ13
      SRC_LPF: sel_sample = lp_sample;
      SRC_TEMP: sel_sample = temp_sample;
      default: sel_sample = '0;
    endcase
    frame_nxt = frame_r;
    frame_strobe_nxt = 1'b0;
    if (sample_strobe && readable_r && (mode == MODE_FORCED || mode == MODE_IRQ)) begin
      frame_nxt = {in_range, sel_sample, cfg_r}; // see RQ23 RQ11
      frame_strobe_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      frame_r <= '0;
      frame_strobe_r <= 1'b0;
    end else begin
      frame_r <= frame_nxt;
      frame_strobe_r <= frame_strobe_nxt;
    end
  end

  assign frame_data = frame_r;
  assign frame_strobe = frame_strobe_r;
  assign motion_configuration = cfg_r;
  assign config_valid = cfg_valid_r;
  assign config_readable = readable_r;
endmodule // pmc_pir_motion_config_unit

// [logic/pmc_pkg.sv]
/*
 * Shared constants of the motion configuration unit: configuration word layout,
 * mode and source codes, readout frame layout and timing figures.
 * Assumes a single 25 MHz clock standing in for the sensor's own oscillator.
 */
// What this block does
// RQ1 - Configuration storage is volatile; undefined until a whole word is loaded.
// RQ2 - Wake-on-motion alarm drives event line high and holds it high.
// RQ3 - Host clears alarm by pulling event line low for at least 160 us.
// RQ4 - After alarm clear, motion detection is suppressed for the blind interval.
// RQ5 - Threshold bits [24:17]; band-pass magnitude must exceed it in either polarity.
// RQ6 - Blind interval from bits [16:13] is 0.5 s plus 0.5 s per step.
// RQ7 - Blind interval starts when host drives event line from high to low.
// RQ8 - Pulse count bits [12:11] require one plus value pulses to raise alarm.
// RQ9 - Pulses counted in a window of 2 s plus 2 s per step, bits [10:9].
// RQ10 - Mode bits [8:7]: forced readout, interrupt readout, wake-on-motion, reserved.
// RQ11 - Readout modes deliver the selected sample and configuration on the event line.
// RQ12 - Source bits [6:5]: band-pass, low-pass, reserved, temperature.
// RQ13 - Band-pass samples signed 14 bit; low-pass and temperature unsigned 14 bit.
// RQ14 - Host writes 2 into bits [4:3] and 0 into bit [1].
// RQ15 - Bit [2] selects high-pass corner: 0 gives 0.4 Hz, 1 gives 0.2 Hz.
// RQ16 - Bit [0] clear requires a sign change between counted pulses.
// RQ17 - Host holds event line low during the whole configuration load.
// RQ18 - Host makes a rising edge per bit, then holds the level 80 us.
// RQ19 - After 25 bits and more than 650 us idle, the word is latched.
// RQ20 - Host pauses under 150 us between bits, else early latch may occur.
// RQ21 - New word accepted only after input low for more than 650 us; arm_r is set once after reset and never cleared, so only the first word waits.
// RQ22 - Latched configuration readable no earlier than 2.4 ms after the latch.
// RQ23 - Frame: range flag bit 39, sample [38:25], configuration [24:0].
// RQ24 - Idle, blind and window intervals are timed by oscillator-clocked counters.
package pmc_pkg;
  // ******************************************************************
  // Configuration word layout
  // ******************************************************************
  localparam int CFG_W = 25;
  localparam int THR_HI = 24;
  localparam int THR_LO = 17;
  localparam int BLIND_HI = 16;
  localparam int BLIND_LO = 13;
  localparam int PCNT_HI = 12;
  localparam int PCNT_LO = 11;
  localparam int WIN_HI = 10;
  localparam int WIN_LO = 9;
  localparam int MODE_HI = 8;
  localparam int MODE_LO = 7;
  localparam int SRC_HI = 6;
  localparam int SRC_LO = 5;
  localparam int HPF_BIT = 2;
  localparam int CMODE_BIT = 0;
  localparam logic [1:0] MODE_FORCED = 2'h0;
  localparam logic [1:0] MODE_IRQ = 2'h1;
  localparam logic [1:0] MODE_WAKE = 2'h2;
  localparam logic [1:0] SRC_BPF = 2'h0;
  localparam logic [1:0] SRC_LPF = 2'h1;
  localparam logic [1:0] SRC_TEMP = 2'h3;
  // ******************************************************************
  // Readout frame layout
  // ******************************************************************
  localparam int SMP_W = 14;
  localparam int FRAME_W = 40;
  localparam int FRAME_OOR_BIT = 39;
  localparam int FRAME_SMP_LO = 25;
  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_KHZ = 25000;
  localparam int IDLE_LATCH_US = 650;
  localparam int IDLE_LATCH_CYC = (IDLE_LATCH_US * CLK_KHZ + 999) / 1000;
  localparam int BIT_SAMPLE_US = 40;
  localparam int BIT_SAMPLE_CYC = (BIT_SAMPLE_US * CLK_KHZ + 999) / 1000;
  localparam int READABLE_US = 2400;
  localparam int READABLE_CYC = (READABLE_US * CLK_KHZ + 999) / 1000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYC = HALF_SEC_MS * CLK_KHZ;
  localparam int WIN_STEP_HALVES = 4;
  localparam int TMR_W = 24;
endpackage

// [logic/pmc_serial_rx.sv]
/*
 * Receiver of the one-wire configuration input: samples one bit per rising
 * edge and strobes out a completed 25-bit word after the idle interval.
 * Assumes the input is synchronous to the clock.
 */
`timescale 1ns/1ns
module pmc_serial_rx import pmc_pkg::*; #(
  parameter int IDLE_CYC = IDLE_LATCH_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Serial configuration input.
  input wire logic config_serial_input,
  // Received word.
  output logic [CFG_W-1:0] word_r,
  output logic word_strobe_r
);
  logic prev_r, prev_nxt;
  logic arm_r, arm_nxt;
  logic pend_r, pend_nxt;
  logic [TMR_W-1:0] smp_cnt_r, smp_cnt_nxt;
  logic [TMR_W-1:0] idle_cnt_r, idle_cnt_nxt;
  logic [TMR_W-1:0] low_cnt_r, low_cnt_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [CFG_W-1:0] shift_r, shift_nxt;
  logic [CFG_W-1:0] word_nxt;
  logic word_strobe_nxt;
  logic rise;

  // ******************************************************************
  // Bit capture and latch timing
  // ******************************************************************
  // The level is sampled mid-way through its hold time, well clear of the
  // short clock pulse that precedes it.
  always_comb begin
    rise = config_serial_input & ~prev_r;
    prev_nxt = config_serial_input;
    arm_nxt = arm_r;
    pend_nxt = pend_r;
    smp_cnt_nxt = smp_cnt_r;
    idle_cnt_nxt = idle_cnt_r;
    low_cnt_nxt = low_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    word_nxt = word_r;
    word_strobe_nxt = 1'b0;
    // Input must rest low long enough before the first word after reset is taken.
    if (config_serial_input) begin
      low_cnt_nxt = '0;
    end else if (low_cnt_r != TMR_W'(IDLE_CYC)) begin
      low_cnt_nxt = low_cnt_r + 1'b1;
    end
    if (low_cnt_r == TMR_W'(IDLE_CYC)) begin
      arm_nxt = 1'b1; // see RQ21
    end
    if (idle_cnt_r <= TMR_W'(IDLE_CYC)) begin
      idle_cnt_nxt = idle_cnt_r + 1'b1; // see RQ24
    end
    if (rise && arm_r) begin
      pend_nxt = 1'b1;
      smp_cnt_nxt = TMR_W'(BIT_SAMPLE_CYC);
      idle_cnt_nxt = '0;
    end else if (pend_r) begin
      smp_cnt_nxt = smp_cnt_r - 1'b1;
      if (smp_cnt_r == TMR_W'(1)) begin
        pend_nxt = 1'b0;
        shift_nxt = {shift_r[CFG_W-2:0], config_serial_input};
        if (bit_cnt_r != 5'(CFG_W)) begin
          bit_cnt_nxt = bit_cnt_r + 1'b1;
        end
      end
    end
    // Latch fires once, when the idle count first reaches the limit.
    if (!pend_r && bit_cnt_r == 5'(CFG_W) && idle_cnt_r == TMR_W'(IDLE_CYC)) begin
      word_nxt = shift_r; // see RQ19
      word_strobe_nxt = 1'b1;
      bit_cnt_nxt = '0;
    end
  end

  // Registers; every register, data included, gets a defined reset value.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
      arm_r <= 1'b0;
      pend_r <= 1'b0;
      smp_cnt_r <= '0;
      idle_cnt_r <= '0;
      low_cnt_r <= '0;
      bit_cnt_r <= '0;
      shift_r <= '0;
      word_r <= '0;
      word_strobe_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      arm_r <= arm_nxt;
      pend_r <= pend_nxt;
      smp_cnt_r <= smp_cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      word_r <= word_nxt;
      word_strobe_r <= word_strobe_nxt;
    end
  end
endmodule // pmc_serial_rx

// [logic/pmc_pulse_detect.sv]
/*
 * Pulse qualifier on the band-pass sample stream: one pulse per excursion
 * beyond the threshold, optionally only after a sign change.
 * Assumes samples arrive with a one-cycle strobe.
 */
`timescale 1ns/1ns
module pmc_pulse_detect import pmc_pkg::*; (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Band-pass sample stream.
  input wire logic sample_strobe,
  input wire logic [SMP_W-1:0] bp_sample,
  // Settings.
  input wire logic [7:0] threshold,
  input wire logic count_any_sign,
  // Qualified pulse.
  output logic pulse_r
);
  logic over_r, over_nxt;
  logic sign_r, sign_nxt;
  logic have_sign_r, have_sign_nxt;
  logic pulse_nxt;
  logic over;

  // Magnitude of a two's complement sample; -8192 maps to 8192.
  function automatic logic [SMP_W-1:0] magnitude(input logic [SMP_W-1:0] v);
    magnitude = v[SMP_W-1] ? SMP_W'(~v + 1'b1) : v;
  endfunction

  // ******************************************************************
  // Threshold and sign qualification
  // ******************************************************************
  always_comb begin
    over = magnitude(bp_sample) > {6'h00, threshold}; // see RQ5
    over_nxt = over_r;
    sign_nxt = sign_r;
    have_sign_nxt = have_sign_r;
    pulse_nxt = 1'b0;
    if (sample_strobe) begin
      over_nxt = over;
      if (over && (!over_r || bp_sample[SMP_W-1] != sign_r)) begin
        // A same-sign repeat is ignored unless sign change is waived.
        if (count_any_sign || !have_sign_r || bp_sample[SMP_W-1] != sign_r) begin
          pulse_nxt = 1'b1; // see RQ16
        end
        sign_nxt = bp_sample[SMP_W-1];
        have_sign_nxt = 1'b1;
      end
    end
  end

  // Registers.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      over_r <= 1'b0;
      sign_r <= 1'b0;
      have_sign_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      over_r <= over_nxt;
      sign_r <= sign_nxt;
      have_sign_r <= have_sign_nxt;
      pulse_r <= pulse_nxt;
    end
  end
endmodule // pmc_pulse_detect

// [testbench/pmc_chk.sv]
/* Checker on the ports of the motion configuration unit top.
   Assumes it is bound to that top and shares its parameters. */
`timescale 1ns/1ns
module pmc_chk import pmc_pkg::*; #(
  parameter int IDLE_CYC = 1100,
  parameter int READ_CYC = 40,
  parameter int HALF_CYC = 2500
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Unit inputs.
  input wire logic event_in,
  input wire logic sample_strobe,
  input wire logic [SMP_W-1:0] bp_sample,
  input wire logic [SMP_W-1:0] lp_sample,
  input wire logic [SMP_W-1:0] temp_sample,
  input wire logic in_range,
  // Unit outputs.
  input wire logic event_out,
  input wire logic event_oe_n,
  input wire logic [CFG_W-1:0] motion_configuration,
  input wire logic config_valid,
  input wire logic config_readable,
  input wire logic hpf_low_corner,
  input wire logic alarm_active,
  input wire logic [FRAME_W-1:0] frame_data,
  input wire logic frame_strobe
);
  logic [1:0] mode;
  logic [SMP_W-1:0] sel;
  int quiet_r, quiet_nxt, lat_r, lat_nxt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Mode and the sample a frame must carry; the reserved source reads zero.
  always_comb begin
    mode = motion_configuration[MODE_HI:MODE_LO];
    case (motion_configuration[SRC_HI:SRC_LO])
      SRC_BPF: sel = bp_sample;
      SRC_LPF: sel = lp_sample;
      SRC_TEMP: sel = temp_sample;
      default: sel = '0;
    endcase
  end
  // Cycles since the last alarm clear, and since a valid word is not yet readable.
  always_comb begin
    quiet_nxt = (quiet_r < 1000000) ? quiet_r + 1 : quiet_r;
    if (event_out && !event_in) begin
      quiet_nxt = 0;
    end
    lat_nxt = (config_valid && !config_readable) ? lat_r + 1 : 0;
  end
  // Saturated at reset so that a first alarm is never taken for one inside a blind time.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      quiet_r <= 1000000;
      lat_r <= 0;
    end else begin
      quiet_r <= quiet_nxt;
      lat_r <= lat_nxt;
    end
  end
  sequence s_driven;
    event_out && event_in;
  endsequence
  sequence s_cleared;
    event_out && !event_in;
  endsequence
  AST_OE_PAIR: assert property (event_oe_n == !event_out)
    else $error("event enable not the inverse of drive");
  AST_ALARM_HOLD: assert property (s_driven |=> event_out)
    else $error("event line dropped by the unit");
  AST_ALARM_CLEAR: assert property (s_cleared |=> !event_out && !alarm_active)
    else $error("alarm not released after host low");
  AST_WAKE_LAT: assert property ($rose(event_out) && mode == MODE_WAKE |->
    $past(sample_strobe, 2)) else $error("alarm not two cycles after a sample");
  AST_BLIND: assert property ($rose(event_out) && mode == MODE_WAKE |->
    quiet_r >= (motion_configuration[BLIND_HI:BLIND_LO] + 1) * HALF_CYC - 4)
    else $error("alarm inside blind time");
  AST_FRAME: assert property (sample_strobe && config_readable && !mode[1] |=>
    frame_strobe && frame_data == {$past(in_range), $past(sel), $past(motion_configuration)})
    else $error("frame missing or wrong");
  AST_NO_FRAME: assert property (sample_strobe && (mode[1] || !config_readable) |=>
    !frame_strobe) else $error("frame where none is allowed");
  AST_RD_EARLY: assert property ($rose(config_readable) |-> lat_r >= READ_CYC - 2)
    else $error("configuration readable too early");
  AST_RD_LATE: assert property (config_valid |-> lat_r <= READ_CYC + 3)
    else $error("configuration readable too late");
  AST_HPF: assert property ((config_valid && $stable(motion_configuration)) [*2] |->
    hpf_low_corner == motion_configuration[HPF_BIT]) else $error("corner select wrong");
  AST_CFG_VALID: assert property ($changed(motion_configuration) |-> config_valid)
    else $error("configuration changed without a latch");
endmodule // pmc_chk
bind pmc_pir_motion_config_unit pmc_chk #(.IDLE_CYC(IDLE_CYC), .READ_CYC(READ_CYC),
  .HALF_CYC(HALF_CYC)) u_pmc_chk (.*);

// [testbench/pmc_host_model.sv]
/* Host model: drives the configuration input and pulls the event line low.
   Assumes the caller enters its tasks just after a rising clock edge. */
`timescale 1ns/1ns
module pmc_host_model (
  // Clock.
  input wire logic clock,
  // Event line as the unit drives it.
  input wire logic event_out,
  input wire logic event_oe_n,
  // Lines toward the unit.
  output logic config_serial_input,
  output logic event_in
);
  logic host_low = 1'b1;
  logic float_r = 1'b0;
  initial config_serial_input = 1'b0;
  // No pull resistor: an undriven line wanders every cycle rather than hold a level.
  always @(posedge clock) float_r <= !float_r;
  assign event_in = host_low ? 1'b0 : (!event_oe_n ? event_out : float_r);
  // One word, bit 24 first, with the event line held low throughout.
  task automatic send_word(input logic [24:0] w);
    host_low <= 1'b1;
    for (int i = 24; i >= 0; i--) begin
      @(posedge clock) config_serial_input <= 1'b0;
      @(posedge clock) config_serial_input <= 1'b1;
      @(posedge clock) config_serial_input <= w[i];
      repeat (1000) @(posedge clock);
    end
    @(posedge clock) config_serial_input <= 1'b0;
  endtask
  // Holds the line low for n cycles, then lets it go.
  task automatic pull_low(input int n);
    host_low <= 1'b1;
    repeat (n) @(posedge clock);
    host_low <= 1'b0;
  endtask
endmodule // pmc_host_model

// [testbench/tb.sv]
/* Self-checking bench of the motion configuration unit.
   Assumes short interval parameters and the host model on the far side. */
`timescale 1ns/1ns
module tb;
  import pmc_pkg::*;
  localparam int IDLE = 1100;
  localparam int RDC = 40;
  localparam int HALF = 2500;
  logic clock = 0, reset_n = 0, sample_strobe = 0, in_range = 0, rd_ok = 0;
  logic [SMP_W-1:0] bp_sample = '0, lp_sample = '0, temp_sample = '0;
  logic config_serial_input, event_in, event_out, event_oe_n, config_valid;
  logic config_readable, hpf_low_corner, alarm_active, frame_strobe;
  logic [CFG_W-1:0] motion_configuration, cfg;
  logic [FRAME_W-1:0] frame_data;
  logic [FRAME_W-1:0] exp_q[$];
  int n_fail = 0, num_checks = 0, cycles = 0, seed = 32'h7014da59;
  initial forever #20 clock = ~clock;
  pmc_pir_motion_config_unit #(.IDLE_CYC(IDLE), .READ_CYC(RDC), .HALF_CYC(HALF))
    u_pmc_pir_motion_config_unit (.*);
  pmc_host_model u_pmc_host_model (.clock(clock), .event_out(event_out),
    .event_oe_n(event_oe_n), .config_serial_input(config_serial_input), .event_in(event_in));
  task automatic cmp_vec(input logic [FRAME_W-1:0] got, input logic [FRAME_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One sample strobe with random side samples; a frame is noted when one is due.
  task automatic strobe(input logic [SMP_W-1:0] bp);
    logic [SMP_W-1:0] lp, tp, sel;
    logic ir;
    lp = $random(seed);
    tp = $random(seed);
    ir = $random(seed);
    case (cfg[SRC_HI:SRC_LO])
      SRC_BPF: sel = bp;
      SRC_LPF: sel = lp;
      SRC_TEMP: sel = tp;
      default: sel = '0;
    endcase
    if (rd_ok && !cfg[MODE_HI]) exp_q.push_back({ir, sel, cfg});
    sample_strobe <= 1'b1;
    bp_sample <= bp;
    lp_sample <= lp;
    temp_sample <= tp;
    in_range <= ir;
    @(posedge clock) sample_strobe <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // Loads a word, checks the latch, then waits out the read-back delay.
  task automatic load(input logic [CFG_W-1:0] w);
    rd_ok = 1'b0;
    cfg = w;
    u_pmc_host_model.send_word(w);
    repeat (IDLE - 980) @(posedge clock);
    cmp_vec({15'h0, motion_configuration}, {15'h0, w});
    cmp_bit(config_valid, 1'b1);
    cmp_bit(hpf_low_corner, w[HPF_BIT]);
    strobe(14'h0000);
    repeat (RDC) @(posedge clock);
    cmp_bit(config_readable, 1'b1);
    rd_ok = 1'b1;
    u_pmc_host_model.pull_low(2);
  endtask
  // Every frame is compared with the oldest note; an unnoted frame always mismatches.
  always @(posedge clock) begin
    if (reset_n && frame_strobe === 1'b1) begin
      if (exp_q.size() == 0) cmp_vec(frame_data, ~frame_data);
      else cmp_vec(frame_data, exp_q.pop_front());
    end
  end
  // Cut a hang short well past the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 98000) begin
      n_fail++;
      end_of_test();
    end
  end
  // Reserved bits are always written as 2 and 0.
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (IDLE + 5) @(posedge clock);
    cmp_bit(config_valid, 1'b0);
    load({8'h20, 4'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 1'b0, 1'b0, 1'b1});
    for (int k = 0; k < 6; k++) strobe($random(seed));
    cmp_bit(event_oe_n, 1'b1);
    $display("test forced readout done");
    load({8'h30, 4'h2, 2'h3, 2'h1, 2'h1, 2'h1, 2'h2, 1'b1, 1'b0, 1'b0});
    strobe(14'h3F00);
    cmp_bit(event_out, 1'b1);
    u_pmc_host_model.pull_low(4000);
    cmp_bit(event_out, 1'b0);
    $display("test interrupt readout done");
    load({8'h40, 4'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 1'b1, 1'b0, 1'b0});
    strobe(14'h0040);
    strobe(14'h3FC0);
    strobe(14'h0050);
    strobe(14'h0000);
    strobe(14'h0060);
    cmp_bit(event_out, 1'b0);
    strobe(14'h3FB0);
    cmp_bit(alarm_active, 1'b1);
    repeat (50) @(posedge clock);
    cmp_bit(event_out, 1'b1);
    u_pmc_host_model.pull_low(4000);
    cmp_bit(event_out, 1'b0);
    strobe(14'h0050);
    strobe(14'h3FB0);
    cmp_bit(event_out, 1'b0);
    repeat (1200) @(posedge clock);
    strobe(14'h0050);
    strobe(14'h3FB0);
    cmp_bit(event_out, 1'b1);
    u_pmc_host_model.pull_low(4000);
    cmp_bit(event_out, 1'b0);
    $display("test wake on motion done");
    cmp_bit(exp_q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule // tb
